//--- rtl/burst_slave.v
// Memory-mapped bus slave with stall, pipelined burst reads, bursts and lock
`include "burst_slave_consts.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - Slave raises stall whenever it cannot take or answer the request.
// R2 - Master waits for stall low before a request counts as taken.
// R3 - Idle master assumes nothing about the stall level.
// R4 - Master holds controls steady under stall, burst start pulse excepted.
// R5 - Slave may raise stall in cycles with no request.
// R6 - Master may start a request while stall is already high.
// R7 - Slave holds stall high throughout reset.
// R8 - Read-valid pulses exactly one cycle per accepted read beat.
// R9 - At least one cycle between read acceptance and its read-valid.
// R10 - Read data may return while new commands are stalled.
// R11 - Pipelined or bursting read interfaces carry the read-valid strobe.
// R12 - Bursting master drives burst length, 1 to 11 bits wide.
// R13 - Maximum burst length is a power of two.
// R14 - n-bit length field encodes at most 2^(n-1); minimum burst is one.
// R15 - Address width at least burst length width (word addresses).
// R16 - Locked read then unlocked write-back; others' writes blocked between.
// R17 - Hold-burst-fields decides how long burst length stays valid.
// R18 - Held: address and length steady all burst; else first beat only.
// R19 - Burst start pulse lasts only the first burst cycle.
// R20 - Lock rises with first locked access, falls on final one.
// R21 - Master takes read data only when read-valid is high, in order.
module burst_slave (
    input wire CLOCK_IN,                       // Bus clock, 125 MHz
    input wire SRST_IN,                        // Synchronous reset, active high
    input wire [`ADDR_W-1:0] ADDRESS_IN,       // Word address
    input wire READ_IN,                        // Read request
    input wire WRITE_IN,                       // Write request
    input wire [`DATA_W-1:0] WRITEDATA_IN,     // Write data
    input wire [`BCOUNT_W-1:0] BURSTCOUNT_IN,  // Beats in burst
    input wire BEGINBURST_IN,                  // First cycle of a burst
    input wire LOCK_IN,                        // Locked sequence in progress
    input wire [`OWNER_W-1:0] OWNER_IN,        // Requesting master, from fabric
    input wire HOLD_BURST_FIELDS_IN,           // Address and length held all burst
    output wire WAITREQUEST_OUT,               // Stall request
    output wire [`DATA_W-1:0] READDATA_OUT,    // Read data
    output wire READDATAVALID_OUT,             // Read data valid, one per beat
    output wire LOCKED_OUT                     // Slave held by a locked sequence
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_WRITE = 3'h4;

    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [`BCOUNT_W-1:0] left_r;
    reg [`BCOUNT_W-1:0] left_nxt;
    reg [`BCOUNT_W-1:0] idx_r;
    reg [`BCOUNT_W-1:0] idx_nxt;
    reg [`ADDR_W-1:0] base_r;
    reg [`ADDR_W-1:0] base_nxt;
    reg rvalid_r;
    reg locked_r;
    reg locked_nxt;
    reg [`OWNER_W-1:0] owner_r;
    reg [`OWNER_W-1:0] owner_nxt;

    wire [`DATA_W-1:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Burst length sanitising
    // Zero is below the legal minimum and counts as one beat; codes above
    // the power-of-two ceiling are clipped rather than wrapping the counter.
    reg [`BCOUNT_W-1:0] blen;

    always @* begin
        if (BURSTCOUNT_IN == `CNT_ZERO) begin
            blen = `CNT_ONE; // [R14]
        end else if (BURSTCOUNT_IN > `MAX_BURST) begin
            blen = `MAX_BURST; // [R13]
        end else begin
            blen = BURSTCOUNT_IN; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stall decision
    wire lock_block = locked_r & WRITE_IN & (OWNER_IN != owner_r);
    // Reads wait while a write burst is open; the port has one address path
    wire wait_w = SRST_IN // [R7]
        | st_r[1] // [R1]
        | lock_block // [R16]
        | (st_r[2] & READ_IN); // [R1]

    assign WAITREQUEST_OUT = wait_w; // [R5]

    wire take_rd = READ_IN & ~wait_w;
    wire take_wr = WRITE_IN & ~READ_IN & ~wait_w;

    // A burst start pulse resynchronises the beat count mid-burst
    wire first_wr = take_wr & (st_r[0] | BEGINBURST_IN); // [R19]

    ////////////////////////////////////////////////////////////////////////////
    // Address generation
    wire [`ADDR_W-1:0] wr_base = HOLD_BURST_FIELDS_IN ? ADDRESS_IN : base_r; // [R18]
    wire [`ADDR_W-1:0] wr_addr = first_wr ? ADDRESS_IN : (wr_base + idx_r); // [R17]
    wire [`ADDR_W-1:0] rd_addr = base_r + idx_r; // [R15]
    wire [`ADDR_W-1:0] mem_addr = st_r[1] ? rd_addr : wr_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing
    always @* begin
        st_nxt = st_r;
        left_nxt = left_r;
        idx_nxt = idx_r;
        base_nxt = base_r;
        case (st_r)
            ST_IDLE: begin
                if (take_rd) begin
                    st_nxt = ST_READ;
                    left_nxt = blen;
                    idx_nxt = `CNT_ZERO;
                    base_nxt = ADDRESS_IN;
                end else if (take_wr) begin
                    base_nxt = ADDRESS_IN;
                    idx_nxt = `CNT_ONE;
                    left_nxt = blen - `CNT_ONE;
                    if (blen != `CNT_ONE) begin
                        st_nxt = ST_WRITE;
                    end
                end
            end
            ST_READ: begin
                // One beat issued per cycle; data shows a cycle later
                idx_nxt = idx_r + `CNT_ONE;
                left_nxt = left_r - `CNT_ONE;
                if (left_r == `CNT_ONE) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (first_wr) begin
                    base_nxt = ADDRESS_IN;
                    idx_nxt = `CNT_ONE;
                    left_nxt = blen - `CNT_ONE;
                    if (blen == `CNT_ONE) begin
                        st_nxt = ST_IDLE;
                    end
                end else if (take_wr) begin
                    idx_nxt = idx_r + `CNT_ONE;
                    left_nxt = left_r - `CNT_ONE;
                    if (left_r == `CNT_ONE) begin
                        st_nxt = ST_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
                left_nxt = `CNT_ZERO;
                idx_nxt = `CNT_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock tracking
    // Only writes from other masters are held off; reads cannot corrupt
    // the read-modify-write in flight.
    always @* begin
        locked_nxt = locked_r;
        owner_nxt = owner_r;
        if (take_rd | take_wr) begin
            if (LOCK_IN) begin
                locked_nxt = 1'b1; // [R20]
                owner_nxt = OWNER_IN;
            end else if (locked_r & (OWNER_IN == owner_r)) begin
                locked_nxt = 1'b0; // [R16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            st_r <= ST_IDLE;
            left_r <= `CNT_ZERO;
            idx_r <= `CNT_ZERO;
            base_r <= `ADDR_ZERO;
            rvalid_r <= 1'b0;
            locked_r <= 1'b0;
            owner_r <= `OWNER_ZERO;
        end else begin
            st_r <= st_nxt;
            left_r <= left_nxt;
            idx_r <= idx_nxt;
            base_r <= base_nxt;
            rvalid_r <= st_r[1]; // [R8] [R9]
            locked_r <= locked_nxt;
            owner_r <= owner_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    word_store #(
        .DATA_W(`DATA_W),
        .ADDR_W(`ADDR_W),
        .DEPTH(`MEM_DEPTH)
    ) u_store (
        .clk_in(CLOCK_IN),
        .we_in(take_wr),
        .re_in(st_r[1]),
        .addr_in(mem_addr),
        .wdata_in(WRITEDATA_IN),
        .rdata_out(mem_rdata)
    );

    // Read data is driven independently of the stall output
    assign READDATA_OUT = mem_rdata; // [R10]
    assign READDATAVALID_OUT = rvalid_r; // [R11]
    assign LOCKED_OUT = locked_r;

endmodule

`default_nettype wire

//--- rtl/burst_slave_consts.vh
// Constants shared by the burst slave and its word store
`ifndef BURST_SLAVE_CONSTS_VH
`define BURST_SLAVE_CONSTS_VH

`define DATA_W 32
`define ADDR_W 4
`define BCOUNT_W 4
`define OWNER_W 2
`define MEM_DEPTH 16
// Largest burst is 2^(BCOUNT_W-1); power of two
`define MAX_BURST 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define ADDR_ZERO 4'h0
`define DATA_ZERO 32'h0000_0000
`define OWNER_ZERO 2'h0

`endif

//--- rtl/word_store.v
// Single-port word memory with registered read data
`default_nettype none

module word_store #(
    parameter DATA_W = 32,
    parameter ADDR_W = 4,
    parameter DEPTH = 16
) (
    input wire clk_in,                 // Clock
    input wire we_in,                  // Write enable
    input wire re_in,                  // Read enable
    input wire [ADDR_W-1:0] addr_in,   // Word address
    input wire [DATA_W-1:0] wdata_in,  // Write data
    output reg [DATA_W-1:0] rdata_out  // Registered read data
);

    reg [DATA_W-1:0] mem_r [0:DEPTH-1];

    always @(posedge clk_in) begin
        if (we_in) begin
            mem_r[addr_in] <= wdata_in;
        end
        if (re_in) begin
            rdata_out <= mem_r[addr_in];
        end
    end

endmodule

`default_nettype wire

//--- test/burst_slave_monitor.sv
// Port checker for the burst slave, bound to its top module
`include "burst_slave_consts.vh"
`default_nettype none
module burst_slave_monitor (
    input wire logic CLOCK_IN, // Clock
    input wire logic SRST_IN, // Reset
    input wire logic READ_IN, // Read
    input wire logic WRITE_IN, // Write
    input wire logic [`BCOUNT_W-1:0] BURSTCOUNT_IN, // Beats
    input wire logic LOCK_IN, // Lock
    input wire logic [`OWNER_W-1:0] OWNER_IN, // Owner
    input wire logic WAITREQUEST_OUT, // Stall
    input wire logic READDATAVALID_OUT, // Valid
    input wire logic LOCKED_OUT // Locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`OWNER_W-1:0] owner_r;
    wire logic stl = WAITREQUEST_OUT;
    wire logic rdv = READDATAVALID_OUT;
    wire logic rd_take = READ_IN && !stl;
    wire logic any_take = (READ_IN || WRITE_IN) && !stl;
    // Shadow of the lock holder, so foreign writes can be judged
    always @(posedge CLOCK_IN) begin
        if (SRST_IN)
            owner_r <= `OWNER_ZERO;
        else if (any_take && LOCK_IN)
            owner_r <= OWNER_IN;
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);
    chk_stall_reset: assert property (disable iff (1'b0)
        SRST_IN |-> stl) else $error("stall low in reset");
    chk_valid_gap: assert property (
        rd_take |=> !rdv) else $error("valid too early");
    chk_one_beat: assert property (
        rd_take && BURSTCOUNT_IN == 4'h1 |-> ##2 rdv ##1 !rdv) else $error("one beat count");
    chk_four_beats: assert property (
        rd_take && BURSTCOUNT_IN == 4'h4 |-> ##2 rdv [*4] ##1 !rdv) else $error("four beats");
    chk_issue_stall: assert property (
        rd_take && BURSTCOUNT_IN == 4'h2 |=> stl [*2] ##1 !stl) else $error("issue stall");
    chk_data_in_stall: assert property (
        rd_take && BURSTCOUNT_IN == 4'h2 |-> ##2 rdv && stl) else $error("no data in stall");
    chk_lock_set: assert property (
        any_take && LOCK_IN |=> LOCKED_OUT) else $error("lock not set");
    chk_foreign_block: assert property (
        LOCKED_OUT && WRITE_IN && OWNER_IN != owner_r |-> stl) else $error("foreign write");
endmodule
bind burst_slave burst_slave_monitor u_chk (.CLOCK_IN, .SRST_IN, .READ_IN, .WRITE_IN,
    .BURSTCOUNT_IN, .LOCK_IN, .OWNER_IN, .WAITREQUEST_OUT, .READDATAVALID_OUT, .LOCKED_OUT);
`default_nettype wire

//--- test/bus_master_model.sv
// Bus master model on the request side of the burst slave
`default_nettype none
module bus_master_model (
    input wire logic clk_in, // Clock
    input wire logic wait_in, // Stall
    input wire logic rdv_in, // Read valid
    input wire logic [31:0] rdata_in, // Read data
    output logic [3:0] addr_out, // Address
    output logic rd_out, // Read
    output logic wr_out, // Write
    output logic [31:0] wdata_out, // Write data
    output logic [3:0] cnt_out, // Beats
    output logic bb_out, // Burst start
    output logic lock_out, // Lock
    output logic [1:0] own_out // Owner
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rq[$];
    logic ok;
    logic drift = 1'b0;
    initial {addr_out, rd_out, wr_out, wdata_out, cnt_out, bb_out, lock_out, own_out} = '0;
    always @(posedge clk_in) if (rdv_in) rq.push_back(rdata_in);
    // Gives up after lim stalled cycles, so a refused request cannot hang
    task automatic xfer(input logic r, input logic [3:0] a, n, input logic l,
            input logic [1:0] o, input logic [31:0] d, input int lim);
        int w;
        ok = 1'b1;
        @(posedge clk_in) #1;
        {rd_out, wr_out, addr_out, cnt_out, lock_out, own_out} = {r, !r, a, n, l, o};
        bb_out = 1'b1;
        fork @(posedge clk_in) #1 bb_out = 1'b0; join_none
        for (int k = 0; k < (r ? 1 : int'(n)); k++) begin
            wdata_out = d + k;
            w = 0;
            @(negedge clk_in);
            while (wait_in && w < lim) begin
                w++;
                @(negedge clk_in);
            end
            ok = ok && !wait_in;
            @(posedge clk_in) #1;
            if (!ok) break;
            // First-beat-only mode lets the address wander after beat one
            if (drift && !r && k + 1 < int'(n)) addr_out = addr_out + 4'h7;
        end
        {rd_out, wr_out, lock_out, addr_out, wdata_out} = {3'h0, ~addr_out, ~wdata_out};
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the burst slave
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hold = 1'b0;
    logic wreq, rdv, lkd, rd, wr, bb, lk;
    logic [3:0] ad, bc;
    logic [1:0] ow;
    logic [31:0] rdat, wd;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    burst_slave u_dut (.CLOCK_IN(clk), .SRST_IN(srst), .ADDRESS_IN(ad), .READ_IN(rd),
        .WRITE_IN(wr), .WRITEDATA_IN(wd), .BURSTCOUNT_IN(bc), .BEGINBURST_IN(bb),
        .LOCK_IN(lk), .OWNER_IN(ow), .HOLD_BURST_FIELDS_IN(hold), .WAITREQUEST_OUT(wreq),
        .READDATA_OUT(rdat), .READDATAVALID_OUT(rdv), .LOCKED_OUT(lkd));
    bus_master_model u_mst (.clk_in(clk), .wait_in(wreq), .rdv_in(rdv), .rdata_in(rdat),
        .addr_out(ad), .rd_out(rd), .wr_out(wr), .wdata_out(wd), .cnt_out(bc),
        .bb_out(bb), .lock_out(lk), .own_out(ow));
    task automatic check(input string nm, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd_burst(input logic [3:0] a, n, input logic [31:0] d);
        u_mst.rq.delete();
        u_mst.xfer(1'b1, a, n, 1'b0, 2'h0, 32'h0000_0000, 20);
        repeat (int'(n) + 3) @(posedge clk);
        #1;
        check("beats", {28'h000_0000, n}, u_mst.rq.size());
        foreach (u_mst.rq[k]) check("rdata", d + k, u_mst.rq[k]);
    endtask
    task automatic t_write_read(input logic [3:0] a, n, input logic [31:0] d);
        u_mst.xfer(1'b0, a, n, 1'b0, 2'h1, d, 20);
        check("write taken", 32'h0000_0001, u_mst.ok);
        rd_burst(a, n, d);
        $display("test write_read done");
    endtask
    task automatic t_lock;
        u_mst.xfer(1'b1, 4'h3, 4'h1, 1'b1, 2'h1, 32'h0000_0000, 20);
        @(posedge clk) #1;
        check("locked", 32'h0000_0001, lkd);
        u_mst.xfer(1'b0, 4'h3, 4'h1, 1'b0, 2'h2, 32'hDEAD_0002, 6);
        check("foreign write", 32'h0000_0000, u_mst.ok);
        u_mst.xfer(1'b0, 4'h3, 4'h1, 1'b0, 2'h1, 32'h1234_5678, 20);
        @(posedge clk) #1;
        check("unlocked", 32'h0000_0000, lkd);
        rd_burst(4'h3, 4'h1, 32'h1234_5678);
        $display("test lock done");
    endtask
    // Out-of-range lengths: above the ceiling clips to eight, zero means one
    task automatic t_clip;
        u_mst.rq.delete();
        u_mst.xfer(1'b1, 4'h1, 4'hF, 1'b0, 2'h0, 32'h0000_0000, 20);
        repeat (12) @(posedge clk);
        #1;
        check("clipped beats", 32'h0000_0008, u_mst.rq.size());
        foreach (u_mst.rq[k]) check("clipped rdata", 32'h3C3C_1000 + k, u_mst.rq[k]);
        u_mst.rq.delete();
        u_mst.xfer(1'b1, 4'h9, 4'h0, 1'b0, 2'h0, 32'h0000_0000, 20);
        repeat (4) @(posedge clk);
        #1;
        check("zero count beats", 32'h0000_0001, u_mst.rq.size());
        check("zero count rdata", 32'h7777_0100, u_mst.rq[0]);
        $display("test clip done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Whole run is about a hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        check("stall in reset", 32'h0000_0001, wreq);
        srst = 1'b0;
        u_mst.drift = 1'b1;
        t_write_read(4'hE, 4'h4, 32'hA5A5_0000);
        t_write_read(4'h5, 4'h2, 32'h0F0F_0010);
        t_write_read(4'h9, 4'h1, 32'h7777_0100);
        u_mst.drift = 1'b0;
        hold = 1'b1;
        t_write_read(4'h1, 4'h8, 32'h3C3C_1000);
        t_clip();
        t_lock();
        wrap_up();
    end
endmodule
`default_nettype wire
